//--- verilog/dma_pkg.sv
// constants, field layouts and carrier types of the eight-channel dma engine
// assumes one clock domain and the plain register port of the top module
package dma_pkg;
  localparam int NCH  = 8;   // channels
  localparam int AW   = 11;  // byte address into dual_port_buffer_ram
  localparam int PW   = 11;  // peripheral register address
  localparam int DW   = 16;  // data word
  localparam int CW   = 10;  // block length / transfer counter
  localparam int SELW = 6;   // request source select
  localparam int NSRC = 64;  // request sources
  localparam int RAW  = 7;   // register port address

  // register index: addr[6]=0 channel space, addr[5:3] channel, addr[2:0] reg
  localparam int            GLB_BIT   = 6;
  localparam logic [2:0]    REG_CTRL  = 3'h0;
  localparam logic [2:0]    REG_STA   = 3'h1;
  localparam logic [2:0]    REG_STB   = 3'h2;
  localparam logic [2:0]    REG_PAD   = 3'h3;
  localparam logic [2:0]    REG_LEN   = 3'h4;
  localparam logic [2:0]    REG_REM   = 3'h5;
  localparam logic [2:0]    REG_CUR   = 3'h6;
  localparam logic [RAW-1:0] REG_INT_STAT = 7'h40;
  localparam logic [RAW-1:0] REG_INT_MASK = 7'h41;
  localparam logic [RAW-1:0] REG_FORCE    = 7'h42;
  localparam logic [RAW-1:0] REG_ACTIVE   = 7'h43;

  localparam logic [1:0] BE_LO   = 2'h1;
  localparam logic [1:0] BE_HI   = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [AW-1:0] STEP_BYTE = 11'h001;
  localparam logic [AW-1:0] STEP_WORD = 11'h002;

  typedef enum logic [1:0] {
    AM_INC   = 2'b00,
    AM_NOINC = 2'b01,
    AM_PIND  = 2'b10
  } amode_t;

  // channel control word, highest bit first
  typedef struct packed {
    logic [SELW-1:0] sel;       // 13:8 request source
    logic            half_ie;   // 7
    logic            pingpong;  // 6
    logic            oneshot;   // 5
    amode_t          amode;     // 4:3
    logic            byte_mode; // 2
    logic            to_periph; // 1 ram to peripheral
    logic            en;        // 0
  } ch_ctrl_t;
  localparam int CTRL_W = $bits(ch_ctrl_t);

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [1:0]    be;
    logic          rd;
    logic          wr;
  } ram_req_t;

  typedef struct packed {
    logic [PW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          rd;
    logic          wr;
  } per_req_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RD   = 4'b0010,
    S_CAP  = 4'b0100,
    S_WR   = 4'b1000
  } eng_t;
endpackage : dma_pkg

//--- verilog/dma_ctrl.sv
// eight-channel dma engine between dual_port_buffer_ram and peripherals
// assumes ram and peripheral read data arrive the cycle after the strobe
`timescale 1ns/1ps
module dma_ctrl #(
  parameter int NCH_P = dma_pkg::NCH
) (
  input  wire logic                                     mclk,
  input  wire logic                                     rst_b,
  input  wire logic [dma_pkg::RAW-1:0]                  addr,
  input  wire logic [dma_pkg::DW-1:0]                   wdata,
  input  wire logic                                     wr_stb,
  input  wire logic                                     rd_stb,
  output logic      [dma_pkg::DW-1:0]                   rdata,
  input  wire logic [dma_pkg::NSRC-1:0]                 src_req,
  input  wire logic [dma_pkg::NSRC-1:0][dma_pkg::AW-1:0] pind_addr,
  output dma_pkg::ram_req_t                             ram_req,
  input  wire logic [dma_pkg::DW-1:0]                   ram_rdata,
  output dma_pkg::per_req_t                             per_req,
  input  wire logic [dma_pkg::DW-1:0]                   per_rdata,
  output logic                                          irq
);
  import dma_pkg::*;

  ch_ctrl_t          cfg_r [NCH_P];
  ch_ctrl_t          cfg_nxt [NCH_P];
  logic [AW-1:0]     sta_r [NCH_P], sta_nxt [NCH_P];
  logic [AW-1:0]     stb_r [NCH_P], stb_nxt [NCH_P];
  logic [AW-1:0]     cur_r [NCH_P], cur_nxt [NCH_P];
  logic [PW-1:0]     pad_r [NCH_P], pad_nxt [NCH_P];
  logic [CW-1:0]     len_r [NCH_P], len_nxt [NCH_P];
  logic [CW-1:0]     rem_r [NCH_P], rem_nxt [NCH_P];
  logic [NCH_P-1:0]  pp_r, pp_nxt, pend_r, pend_nxt;
  logic [2*NCH_P-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [DW-1:0]     rdata_r, rdata_nxt;
  logic              irq_r, irq_nxt;
  eng_t              st_r, st_nxt;
  logic [2:0]        gch_r, gch_nxt, gnt, rch;
  logic              gnt_vld;
  logic [AW-1:0]     xaddr_r, xaddr_nxt;
  ram_req_t          ram_r, ram_nxt;
  per_req_t          per_r, per_nxt;
  logic [CW-1:0]     rem_dec;

  function automatic logic [AW-1:0] step_of(input logic bm);
    return bm ? STEP_BYTE : STEP_WORD;
  endfunction : step_of

  function automatic logic [1:0] be_of(input logic bm, input logic a0);
    return bm ? (a0 ? BE_HI : BE_LO) : BE_WORD;
  endfunction : be_of

  function automatic logic [7:0] lane_of(input logic [DW-1:0] d,
                                         input logic a0);
    return a0 ? d[15:8] : d[7:0];
  endfunction : lane_of

  assign rdata   = rdata_r;
  assign irq     = irq_r;
  assign ram_req = ram_r;
  assign per_req = per_r;
  assign rch     = addr[5:3];
  assign rem_dec = rem_r[gch_r] - 1'b1;

  // lowest eligible index wins; scan top down so the last hit is lowest
  always_comb begin
    gnt     = '0;
    gnt_vld = 1'b0;
    for (int c = NCH_P - 1; c >= 0; c--) begin
      if (pend_r[c] && cfg_r[c].en) begin
        gnt     = 3'(c);
        gnt_vld = 1'b1;
      end
    end
  end

  // channel registers, request latches and interrupt status
  always_comb begin
    cfg_nxt  = cfg_r;
    sta_nxt  = sta_r;
    stb_nxt  = stb_r;
    cur_nxt  = cur_r;
    pad_nxt  = pad_r;
    len_nxt  = len_r;
    rem_nxt  = rem_r;
    pp_nxt   = pp_r;
    pend_nxt = pend_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    rdata_nxt = '0;
    if (rd_stb) begin
      if (!addr[GLB_BIT]) begin
        case (addr[2:0])
          REG_CTRL: rdata_nxt = DW'(cfg_r[rch]);
          REG_STA:  rdata_nxt = DW'(sta_r[rch]);
          REG_STB:  rdata_nxt = DW'(stb_r[rch]);
          REG_PAD:  rdata_nxt = DW'(pad_r[rch]);
          REG_LEN:  rdata_nxt = DW'(len_r[rch]);
          REG_REM:  rdata_nxt = DW'(rem_r[rch]);
          REG_CUR:  rdata_nxt = DW'(cur_r[rch]);
          default:  rdata_nxt = '0;
        endcase
      end else begin
        case (addr)
          REG_INT_STAT: begin
            rdata_nxt = stat_r;
            stat_nxt  = '0;
          end
          REG_INT_MASK: rdata_nxt = mask_r;
          REG_ACTIVE:   rdata_nxt = {pp_r, pend_r};
          default:      rdata_nxt = '0;
        endcase
      end
    end
    if (wr_stb) begin
      if (!addr[GLB_BIT]) begin
        case (addr[2:0])
          REG_CTRL: begin
            cfg_nxt[rch] = ch_ctrl_t'(wdata[CTRL_W-1:0]);
            if (cfg_nxt[rch].en && !cfg_r[rch].en) begin
              cur_nxt[rch] = sta_r[rch];
              rem_nxt[rch] = len_r[rch];
              pp_nxt[rch]  = 1'b0;
            end
          end
          REG_STA: sta_nxt[rch] = wdata[AW-1:0];
          REG_STB: stb_nxt[rch] = wdata[AW-1:0];
          REG_PAD: pad_nxt[rch] = wdata[PW-1:0];
          REG_LEN: len_nxt[rch] = wdata[CW-1:0];
          default: ;
        endcase
      end else if (addr == REG_INT_MASK) begin
        mask_nxt = wdata[2*NCH_P-1:0];
      end
    end
    // a granted request is consumed before new ones are caught
    if (st_r == S_IDLE && gnt_vld) begin
      pend_nxt[gnt] = 1'b0;
    end
    // block bookkeeping after the write strobe of each transfer
    if (st_r == S_WR) begin
      rem_nxt[gch_r] = rem_dec;
      if (cfg_r[gch_r].amode == AM_INC) begin
        cur_nxt[gch_r] = cur_r[gch_r] + step_of(cfg_r[gch_r].byte_mode);
      end
      if (cfg_r[gch_r].half_ie && len_r[gch_r] > 1 &&
          rem_dec == len_r[gch_r] - (len_r[gch_r] >> 1)) begin
        stat_nxt[NCH_P + gch_r] = 1'b1;
      end
      if (rem_dec == '0) begin
        stat_nxt[gch_r] = 1'b1;
        rem_nxt[gch_r]  = len_r[gch_r];
        if (cfg_r[gch_r].oneshot) begin
          cfg_nxt[gch_r].en = 1'b0;
        end
        if (cfg_r[gch_r].pingpong) begin
          pp_nxt[gch_r]  = ~pp_r[gch_r];
          cur_nxt[gch_r] = pp_r[gch_r] ? sta_r[gch_r] : stb_r[gch_r];
        end else begin
          cur_nxt[gch_r] = sta_r[gch_r];
        end
      end
    end
    // sets come last so an event beats a clear in the same cycle
    for (int c = 0; c < NCH_P; c++) begin
      // a channel switched off forgets what it had caught, so a stale
      // request cannot fire a transfer the moment it is enabled again
      if (!cfg_nxt[c].en) begin
        pend_nxt[c] = 1'b0;
      end
      if (cfg_nxt[c].en && src_req[cfg_r[c].sel]) begin
        pend_nxt[c] = 1'b1;
      end
      if (cfg_nxt[c].en && wr_stb && addr == REG_FORCE && wdata[c]) begin
        pend_nxt[c] = 1'b1;
      end
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH_P; c++) begin
        cfg_r[c] <= '0;
        sta_r[c] <= '0;
        stb_r[c] <= '0;
        cur_r[c] <= '0;
        pad_r[c] <= '0;
        len_r[c] <= '0;
        rem_r[c] <= '0;
      end
      pp_r    <= '0;
      pend_r  <= '0;
      stat_r  <= '0;
      mask_r  <= '0;
      rdata_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      sta_r   <= sta_nxt;
      stb_r   <= stb_nxt;
      cur_r   <= cur_nxt;
      pad_r   <= pad_nxt;
      len_r   <= len_nxt;
      rem_r   <= rem_nxt;
      pp_r    <= pp_nxt;
      pend_r  <= pend_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // transfer engine: read one side, capture, write the other side
  always_comb begin
    st_nxt    = st_r;
    gch_nxt   = gch_r;
    xaddr_nxt = xaddr_r;
    ram_nxt   = ram_r;
    per_nxt   = per_r;
    ram_nxt.rd = 1'b0;
    ram_nxt.wr = 1'b0;
    per_nxt.rd = 1'b0;
    per_nxt.wr = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (gnt_vld) begin
          gch_nxt   = gnt;
          xaddr_nxt = (cfg_r[gnt].amode == AM_PIND) ?
                      pind_addr[cfg_r[gnt].sel] : cur_r[gnt];
          if (cfg_r[gnt].to_periph) begin
            ram_nxt.addr = xaddr_nxt;
            ram_nxt.be   = be_of(cfg_r[gnt].byte_mode, xaddr_nxt[0]);
            ram_nxt.rd   = 1'b1;
          end else begin
            per_nxt.addr = pad_r[gnt];
            per_nxt.rd   = 1'b1;
          end
          st_nxt = S_RD;
        end
      end
      S_RD: st_nxt = S_CAP;
      S_CAP: begin
        if (cfg_r[gch_r].to_periph) begin
          per_nxt.addr  = pad_r[gch_r];
          per_nxt.wdata = cfg_r[gch_r].byte_mode ?
                          {8'h00, lane_of(ram_rdata, xaddr_r[0])} : ram_rdata;
          per_nxt.wr    = 1'b1;
        end else begin
          ram_nxt.addr  = xaddr_r;
          ram_nxt.be    = be_of(cfg_r[gch_r].byte_mode, xaddr_r[0]);
          ram_nxt.wdata = cfg_r[gch_r].byte_mode ?
                          {2{per_rdata[7:0]}} : per_rdata;
          ram_nxt.wr    = 1'b1;
        end
        st_nxt = S_WR;
      end
      S_WR:    st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= S_IDLE;
      gch_r   <= '0;
      xaddr_r <= '0;
      ram_r   <= '0;
      per_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      gch_r   <= gch_nxt;
      xaddr_r <= xaddr_nxt;
      ram_r   <= ram_nxt;
      per_r   <= per_nxt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_arb_lowest: assert property (st_r == S_IDLE && gnt_vld |->
    (pend_r & {cfg_r[7].en, cfg_r[6].en, cfg_r[5].en, cfg_r[4].en,
     cfg_r[3].en, cfg_r[2].en, cfg_r[1].en, cfg_r[0].en} &
     ((8'h01 << gnt) - 8'h01)) == '0)
    else $error("lower channel pending but not granted");
  a_xfer_seq: assert property ($rose(st_r == S_RD) |->
    (ram_r.rd || per_r.rd) ##2 (ram_r.wr || per_r.wr) ##1 st_r == S_IDLE)
    else $error("transfer sequence broken");
  a_inc_addr: assert property (st_r == S_WR &&
    cfg_r[gch_r].amode == AM_INC && rem_dec != '0 |=>
    cur_r[gch_r] == $past(cur_r[gch_r]) +
    step_of($past(cfg_r[gch_r].byte_mode)))
    else $error("post-increment address wrong");
  a_noinc_addr: assert property (st_r == S_WR &&
    cfg_r[gch_r].amode == AM_NOINC && rem_dec != '0 |=>
    cur_r[gch_r] == $past(cur_r[gch_r]))
    else $error("fixed address moved");
  a_cnt_dec: assert property (st_r == S_WR && rem_dec != '0 |=>
    rem_r[gch_r] == $past(rem_r[gch_r]) - 1'b1)
    else $error("counter did not decrement");
  a_oneshot_stop: assert property (st_r == S_WR && rem_dec == '0 &&
    cfg_r[gch_r].oneshot |=> !cfg_r[gch_r].en && stat_r[gch_r] &&
    (irq_r || !mask_r[gch_r]))
    else $error("one-shot block did not stop");
  a_pp_swap: assert property (st_r == S_WR && rem_dec == '0 &&
    cfg_r[gch_r].pingpong |=> pp_r[gch_r] != $past(pp_r[gch_r]))
    else $error("ping-pong select not swapped");
  a_irq_level: assert property (|(stat_r & mask_r) |-> irq_r)
    else $error("unmasked status without interrupt");
  a_stat_clear: assert property (rd_stb && addr == REG_INT_STAT &&
    st_r != S_WR |=> stat_r == '0 && !irq_r)
    else $error("status read did not clear the interrupt");
  a_pind_keep: assert property (st_r == S_WR &&
    cfg_r[gch_r].amode == AM_PIND && rem_dec != '0 |=>
    cur_r[gch_r] == $past(cur_r[gch_r]))
    else $error("peripheral-indirect moved the channel address");
  // lane checks assume software leaves a busy channel's control alone
  a_byte_zext: assert property (per_r.wr && cfg_r[gch_r].byte_mode |->
    per_r.wdata[15:8] == 8'h00)
    else $error("byte to peripheral not zero-extended");
  a_byte_lane: assert property (ram_r.wr && cfg_r[gch_r].byte_mode |->
    ram_r.be != BE_WORD)
    else $error("byte write touched both lanes");
  c_pingpong: cover property (st_r == S_WR && rem_dec == '0 &&
    cfg_r[gch_r].pingpong);
  c_two_req: cover property (st_r == S_IDLE && $countones(pend_r) > 1);
  c_half: cover property ($rose(stat_r[NCH_P]));
  c_byte_out: cover property (per_r.wr && cfg_r[gch_r].byte_mode);
endmodule : dma_ctrl

//--- dv/dma_partner.sv
// behavioural dual_port_buffer_ram and peripheral register file
// assumes one-cycle strobes from dma_ctrl; read data stand one cycle only
`timescale 1ns/1ps
module dma_partner (
  input  wire logic              mclk,
  input  wire dma_pkg::ram_req_t ram_req,
  output logic [dma_pkg::DW-1:0] ram_rdata,
  input  wire dma_pkg::per_req_t per_req,
  output logic [dma_pkg::DW-1:0] per_rdata
);
  import dma_pkg::*;
  logic [7:0]    mem  [0:2047];
  logic [DW-1:0] preg [0:15];
  logic [AW-1:0] wa;
  assign wa = {ram_req.addr[AW-1:1], 1'b0};
  initial begin
    ram_rdata = '0;
    per_rdata = '0;
  end
  // released lines show the inverse, so a stale word never passes a check
  always @(posedge mclk) begin
    ram_rdata <= ram_req.rd ? {mem[wa+1], mem[wa]} : ~ram_rdata;
    per_rdata <= per_req.rd ? preg[per_req.addr[3:0]] : ~per_rdata;
    if (ram_req.wr && ram_req.be[0]) mem[wa] <= ram_req.wdata[7:0];
    if (ram_req.wr && ram_req.be[1]) mem[wa+1] <= ram_req.wdata[15:8];
    if (per_req.wr) preg[per_req.addr[3:0]] <= per_req.wdata;
  end
endmodule : dma_partner

//--- dv/tb_top.sv
// self-checking bench for dma_ctrl: register port tasks, transfer checks
// assumes dma_partner answers ram and peripheral reads one cycle late
`timescale 1ns/1ps
module tb_top;
  import dma_pkg::*;
  logic                    mclk, rst_b, wr_stb, rd_stb, irq;
  logic [RAW-1:0]          addr;
  logic [DW-1:0]           wdata, rdata, ram_rdata, per_rdata, v;
  logic [NSRC-1:0]         src_req;
  logic [NSRC-1:0][AW-1:0] pind_addr;
  ram_req_t                ram_req, rq;
  per_req_t                per_req, pq;
  int                      failures, n_tests, n_xfer, k, i;

  dma_ctrl u_dma_ctrl (.mclk(mclk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .src_req(src_req), .pind_addr(pind_addr), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .per_req(per_req), .per_rdata(per_rdata),
    .irq(irq));
  dma_partner u_dma_partner (.mclk(mclk), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .per_req(per_req), .per_rdata(per_rdata));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (ram_req.rd || per_req.rd) n_xfer++;

  function automatic logic [RAW-1:0] ra(int c, logic [2:0] r);
    return {1'b0, c[2:0], r};
  endfunction : ra
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [RAW-1:0] a, logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [RAW-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic go(int s);
    @(posedge mclk);
    src_req[s] <= 1'b1;
    @(posedge mclk);
    src_req[s] <= 1'b0;
  endtask : go
  task automatic wt;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      #1;
      if (ram_req.wr || per_req.wr) break;
    end
    rq = ram_req;
    pq = per_req;
    if (n == 20) chk("xfer wait", 0, 1);
  endtask : wt
  task automatic stop_test;
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    stop_test();
  end

  initial begin
    {rst_b, wr_stb, rd_stb, addr, wdata, src_req, pind_addr} = '0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rd(ra(0, REG_CTRL));
    chk("ctrl0 reset", v, 0);
    rd(7'h7f);
    chk("unmapped", v, 0);
    for (i = 0; i < 8; i++) begin
      u_dma_partner.mem[16'h0100 + i] = 8'h11 + i[7:0];
    end
    // ch0: ram to peripheral, words, post-increment, half interrupt
    wr(REG_INT_MASK, 16'h0101);
    wr(ra(0, REG_STA), 16'h0100);
    wr(ra(0, REG_PAD), 16'h0025);
    wr(ra(0, REG_LEN), 16'h0004);
    wr(ra(0, REG_CTRL), 16'h05a3);
    for (i = 0; i < 4; i++) begin
      go(5);
      wt();
      chk("ch0 pad", pq.addr, 32'h0025);
      v = {8'(8'h12 + 2 * i), 8'(8'h11 + 2 * i)};
      chk("ch0 data", pq.wdata, v);
      if (i == 1) begin
        repeat (3) @(posedge mclk);
        chk("irq half", irq, 1);
        rd(REG_INT_STAT);
        chk("stat half", v, 16'h0100);
        repeat (2) @(posedge mclk);
        chk("irq clear", irq, 0);
      end
    end
    repeat (2) @(posedge mclk);
    rd(REG_INT_STAT);
    chk("stat done", v, 16'h0001);
    rd(ra(0, REG_CTRL));
    chk("oneshot off", v, 16'h05a2);
    rd(ra(0, REG_REM));
    chk("reload", v, 16'h0004);
    // ch1: peripheral to ram, bytes, fixed address
    wr(ra(1, REG_STA), 16'h0201);
    wr(ra(1, REG_PAD), 16'h0031);
    wr(ra(1, REG_LEN), 16'h0002);
    wr(ra(1, REG_CTRL), 16'h092d);
    for (i = 0; i < 2; i++) begin
      u_dma_partner.preg[1] = (i == 0) ? 16'h00a5 : 16'h005a;
      go(9);
      wt();
      chk("ch1 addr", rq.addr, 32'h0201);
      chk("ch1 lane", rq.be, 32'h2);
      chk("ch1 byte", rq.wdata[15:8], (i == 0) ? 8'ha5 : 8'h5a);
    end
    repeat (2) @(posedge mclk);
    chk("ram byte", u_dma_partner.mem[16'h0201], 8'h5a);
    // ch2: peripheral supplies the ram address
    pind_addr[12] <= 11'h300;
    u_dma_partner.preg[2] = 16'h1234;
    wr(ra(2, REG_PAD), 16'h0032);
    wr(ra(2, REG_LEN), 16'h0001);
    wr(ra(2, REG_CTRL), 16'h0c31);
    go(12);
    wt();
    chk("pind addr", rq.addr, 32'h0300);
    chk("pind data", rq.wdata, 32'h1234);
    chk("pind be", rq.be, 32'h3);
    // ch6: ram to peripheral, byte from the odd lane, fixed address
    wr(ra(6, REG_STA), 16'h0103);
    wr(ra(6, REG_PAD), 16'h0036);
    wr(ra(6, REG_LEN), 16'h0001);
    wr(ra(6, REG_CTRL), 16'h002f);
    wr(REG_FORCE, 16'h0040);
    wt();
    chk("byte out", pq.wdata, 32'h0014);
    chk("byte pad", pq.addr, 32'h0036);
    // ch3 ping-pong auto-repeat against ch4, both forced at once
    wr(ra(3, REG_STA), 16'h0040);
    wr(ra(3, REG_STB), 16'h0080);
    wr(ra(3, REG_PAD), 16'h0033);
    wr(ra(3, REG_LEN), 16'h0001);
    wr(ra(3, REG_CTRL), 16'h0043);
    wr(ra(4, REG_STA), 16'h0060);
    wr(ra(4, REG_PAD), 16'h0034);
    wr(ra(4, REG_LEN), 16'h0001);
    wr(ra(4, REG_CTRL), 16'h0023);
    wr(REG_FORCE, 16'h0018);
    wt();
    chk("first grant", pq.addr, 32'h0033);
    wt();
    chk("second grant", pq.addr, 32'h0034);
    rd(ra(3, REG_CUR));
    chk("pingpong b", v, 16'h0080);
    rd(REG_ACTIVE);
    chk("active", v, 16'h0800);
    rd(ra(3, REG_CTRL));
    chk("autorepeat", v, 16'h0043);
    wr(REG_FORCE, 16'h0008);
    wt();
    chk("buffer b", rq.addr, 32'h0080);
    // disabled channel drops its request
    k = n_xfer;
    wr(ra(5, REG_CTRL), 16'h1400);
    wr(REG_FORCE, 16'h0020);
    go(20);
    wr(ra(5, REG_CTRL), 16'h1401);
    repeat (8) @(posedge mclk);
    chk("dropped", n_xfer, k);
    rd(ra(0, REG_CTRL));
    chk("ch0 kept", v, 16'h05a2);
    stop_test();
  end
endmodule : tb_top
